// >>> logic/act_pkg.sv
// Package for the converter clock tree and shared interrupt pin block
// Operation
// - With the pin mode upper bit at 0 (reset value) the shared pin is the interrupt output for all four sources.
// - In interrupt mode the pin mode lower bit picks the idle level, released or driven high.
// - With the pin mode upper bit at 1 the pin carries the modulator bitstream, updated on the sample clock.
// - In bitstream mode a pending power-on-reset or CRC interrupt forces the pin low until software clears it.
// - The device senses the real pin level and must see it high while the pin is released in interrupt mode.
// - A two-bit clock source field in the first configuration register makes the master clock pin an input or an output.
// - The analog master clock is the master clock divided by the prescale factor.
// - The sample clock is the analog master clock divided by 4, one sample and one modulator bit per period.
// - In continuous mode results come at the sample clock divided by the oversampling ratio.
// - In interrupt mode each new result is announced by a data-ready pulse on the interrupt pin.
// - Serial clock and master clock are unrelated; the master clock runs continuously while converting.
package act_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ACT_REG_CONFIG = 8'h00;
  localparam logic [7:0] ACT_REG_OSR = 8'h04;
  localparam logic [7:0] ACT_REG_STATUS = 8'h08;
  localparam logic [7:0] ACT_REG_MASK = 8'h0C;
  localparam logic [7:0] ACT_REG_PIN = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ACT_CLKSEL_LSB = 0;
  localparam int ACT_PRE_LSB = 2;
  localparam int ACT_IRQMODE_LSB = 4;
  localparam int ACT_CONV_BIT = 6;
  localparam logic [31:0] ACT_CONFIG_RST = 32'h0000_0000;
  localparam logic [16:0] ACT_OSR_RST = 17'h0_0100;
  localparam logic [16:0] ACT_OSR_MIN = 17'h0_0001;
  localparam logic [3:0] ACT_MASK_RST = 4'h0;
  localparam int ACT_SAMPLE_DIV = 4;

  // Interrupt sources
  localparam int ACT_IRQ_DRDY = 0;
  localparam int ACT_IRQ_CRC = 1;
  localparam int ACT_IRQ_POR = 2;
  localparam int ACT_IRQ_PIN = 3;

  // Clock source codes: upper bit set selects internal oscillator, lower bit then also drives the analog master clock level on the pin
  typedef enum logic [1:0] {
    ACT_CLK_EXT0 = 2'b00,
    ACT_CLK_EXT1 = 2'b01,
    ACT_CLK_INT_NOOUT = 2'b10,
    ACT_CLK_INT_OUT = 2'b11
  } act_clksel_t;

  typedef struct packed {
    logic o;
    logic oe;
  } act_pin_t;

  function automatic logic [3:0] act_pre_div(input logic [1:0] code);
    act_pre_div = 4'h1 << code;
  endfunction

endpackage

// >>> logic/act_clock_irq.sv
// Clock tree, data-rate generator and shared interrupt/bitstream pin
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module act_clock_irq
  import act_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic mclk_pin_in,
  input wire logic osc_clk_in,
  input wire logic modulator_bit_in,
  input wire logic crc_error_in,
  input wire logic por_event_in,
  input wire logic irq_pin_sense_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mclk_pin_out,
  output logic mclk_pin_oe_out,
  output logic irq_pin_out,
  output logic irq_pin_oe_out,
  output logic sample_tick_out,
  output logic data_ready_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0] clk_sel;
  logic [1:0] prescale;
  logic [1:0] irq_mode;
  logic conv_en;
  logic [16:0] oversampling_ratio;
  logic [3:0] status;
  logic [3:0] mask;
  logic wr_en;
  logic rd_en;
  logic [3:0] clr_bits;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign clr_bits = (wr_en && paddr == ACT_REG_STATUS) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_sel <= ACT_CONFIG_RST[ACT_CLKSEL_LSB +: 2];
      prescale <= ACT_CONFIG_RST[ACT_PRE_LSB +: 2];
      irq_mode <= ACT_CONFIG_RST[ACT_IRQMODE_LSB +: 2];
      conv_en <= ACT_CONFIG_RST[ACT_CONV_BIT];
      oversampling_ratio <= ACT_OSR_RST;
      mask <= ACT_MASK_RST;
    end else if (wr_en) begin
      if (paddr == ACT_REG_CONFIG) begin
        clk_sel <= pwdata[ACT_CLKSEL_LSB +: 2];
        prescale <= pwdata[ACT_PRE_LSB +: 2];
        irq_mode <= pwdata[ACT_IRQMODE_LSB +: 2];
        conv_en <= pwdata[ACT_CONV_BIT];
      end
      if (paddr == ACT_REG_OSR) begin
        // Zero ratio would make the data rate divider wrap only every 131072 samples
        oversampling_ratio <= (pwdata[16:0] == 17'h0_0000) ? ACT_OSR_MIN : pwdata[16:0];
      end
      if (paddr == ACT_REG_MASK) begin
        mask <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // ----------------------------------------------------------------
  logic mapped;
  assign mapped = paddr == ACT_REG_CONFIG || paddr == ACT_REG_OSR ||
                  paddr == ACT_REG_STATUS || paddr == ACT_REG_MASK ||
                  paddr == ACT_REG_PIN;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ACT_REG_CONFIG: prdata <= {25'h000_0000, conv_en, irq_mode, prescale, clk_sel};
          ACT_REG_OSR: prdata <= {15'h0000, oversampling_ratio};
          ACT_REG_STATUS: prdata <= {28'h000_0000, status};
          ACT_REG_MASK: prdata <= {28'h000_0000, mask};
          ACT_REG_PIN: prdata <= {30'h0000_0000, irq_pin_sense_in, irq_pin_out};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Master clock select and prescaler
  // ----------------------------------------------------------------
  // Both clock sources are sampled as levels; they must be slower than clk_in / 2.
  logic mclk_lvl;
  logic mclk_prev;
  logic mclk_rise;
  logic [2:0] pre_cnt;
  logic analog_master_clock_tick;
  logic analog_master_clock_lvl;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mclk_lvl <= 1'b0;
      mclk_prev <= 1'b0;
    end else begin
      mclk_lvl <= clk_sel[1] ? osc_clk_in : mclk_pin_in;
      mclk_prev <= mclk_lvl;
    end
  end
  assign mclk_rise = mclk_lvl && !mclk_prev;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_cnt <= 3'h0;
      analog_master_clock_tick <= 1'b0;
      analog_master_clock_lvl <= 1'b0;
    end else begin
      analog_master_clock_tick <= 1'b0;
      if (mclk_rise) begin
        if (pre_cnt >= 3'(act_pre_div(prescale) - 4'h1)) begin
          pre_cnt <= 3'h0;
          analog_master_clock_tick <= 1'b1;
          analog_master_clock_lvl <= !analog_master_clock_lvl;
        end else begin
          pre_cnt <= pre_cnt + 3'h1;
        end
      end
    end
  end

  // Pin becomes output only for the internal-oscillator-with-output code
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mclk_pin_out <= 1'b0;
      mclk_pin_oe_out <= 1'b0;
    end else begin
      mclk_pin_out <= analog_master_clock_lvl;
      mclk_pin_oe_out <= clk_sel == ACT_CLK_INT_OUT;
    end
  end

  // ----------------------------------------------------------------
  // Sample clock and data rate
  // ----------------------------------------------------------------
  logic [1:0] smp_cnt;
  logic smp_tick;
  logic [16:0] osr_cnt;
  logic drdy_tick;
  logic mod_bit;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      smp_cnt <= 2'h0;
      smp_tick <= 1'b0;
      sample_tick_out <= 1'b0;
    end else begin
      smp_tick <= 1'b0;
      if (analog_master_clock_tick) begin
        smp_cnt <= smp_cnt + 2'h1;
        smp_tick <= smp_cnt == 2'(ACT_SAMPLE_DIV - 1);
      end
      sample_tick_out <= smp_tick;
    end
  end

  // Modulator bit refreshed once per sample, on an analog clock edge
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mod_bit <= 1'b0;
    end else if (smp_tick) begin
      mod_bit <= modulator_bit_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osr_cnt <= 17'h0_0000;
      drdy_tick <= 1'b0;
    end else begin
      drdy_tick <= 1'b0;
      if (!conv_en) begin
        osr_cnt <= 17'h0_0000;
      end else if (smp_tick) begin
        if (osr_cnt >= oversampling_ratio - 17'h0_0001) begin
          osr_cnt <= 17'h0_0000;
          drdy_tick <= 1'b1;
        end else begin
          osr_cnt <= osr_cnt + 17'h0_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------------------------------
  logic [3:0] events;
  logic sense_s1;
  logic sense_s2;
  logic pin_fault;
  logic oe_d1;
  logic oe_d2;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sense_s1 <= 1'b1;
      sense_s2 <= 1'b1;
      oe_d1 <= 1'b0;
      oe_d2 <= 1'b0;
    end else begin
      sense_s1 <= irq_pin_sense_in;
      sense_s2 <= sense_s1;
      oe_d1 <= irq_pin_oe_out;
      oe_d2 <= oe_d1;
    end
  end
  // Pin stuck low while nothing pending: pull-up missing or contention
  // Enable history matches the sense delay, so our own low pulse never counts
  assign pin_fault = !sense_s2 && !oe_d2 && !oe_d1 && !irq_pin_oe_out &&
                     !irq_mode[1];

  assign events[ACT_IRQ_DRDY] = drdy_tick;
  assign events[ACT_IRQ_CRC] = crc_error_in;
  assign events[ACT_IRQ_POR] = por_event_in;
  assign events[ACT_IRQ_PIN] = pin_fault;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status <= 4'h0;
    end else begin
      status <= (status & ~clr_bits) | events;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & mask);
    end
  end

  // ----------------------------------------------------------------
  // Shared pin drive
  // ----------------------------------------------------------------
  logic drdy_pulse;
  logic lvl_pending;
  act_pin_t next_pin;

  // Data ready is a one-cycle low pulse; others hold low until cleared
  assign drdy_pulse = drdy_tick;
  assign lvl_pending = status[ACT_IRQ_POR] || status[ACT_IRQ_CRC];

  always_comb begin
    next_pin.o = 1'b1;
    next_pin.oe = 1'b1;
    if (irq_mode[1]) begin
      next_pin.o = lvl_pending ? 1'b0 : mod_bit;
    end else if (drdy_pulse || (|status[3:1])) begin
      next_pin.o = 1'b0;
    end else begin
      next_pin.oe = irq_mode[0];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_pin_out <= 1'b1;
      irq_pin_oe_out <= 1'b0;
      data_ready_out <= 1'b0;
    end else begin
      irq_pin_out <= next_pin.o;
      irq_pin_oe_out <= next_pin.oe;
      data_ready_out <= drdy_tick;
    end
  end

endmodule

// >>> testbench/act_clock_irq_sva.sv
// Checker on the top ports of the clock tree and shared pin block
`timescale 1ns/1ps
module act_clock_irq_sva (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mclk_pin_oe_out,
  input wire logic sample_tick_out,
  input wire logic data_ready_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  sequence s_setup; psel && !penable; endsequence
  property p_ready_setup; s_setup |=> pready; endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no answer");
  property p_ready_access; pready |-> psel && penable; endproperty
  a_ready_access: assert property (p_ready_access) else $error("stray pready");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
  property p_err_rdata; pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_err_rdata: assert property (p_err_rdata) else $error("refused read data");
  // Master edges come at most every other cycle
  property p_tick_gap; sample_tick_out |=> !sample_tick_out [*7]; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
  property p_drdy_gap; data_ready_out |=> !data_ready_out [*7]; endproperty
  a_drdy_gap: assert property (p_drdy_gap) else $error("results too close");
  property p_oe_cause; $changed(mclk_pin_oe_out) |-> $past(wr_acc) || $past(wr_acc, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("clock pin turned unasked");
endmodule
bind act_clock_irq act_clock_irq_sva u_sva (.clk_in, .resetn_in, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .mclk_pin_oe_out, .sample_tick_out, .data_ready_out);

// >>> testbench/act_host_model.sv
// Host side: master clock source and pulled-up shared pin
`timescale 1ns/1ps
module act_host_model (
  input wire logic clk_in,
  input wire logic pin_drive_in,
  input wire logic pin_oe_in,
  input wire logic hold_low_in,
  output logic mclk_out,
  output logic pin_level_out,
  output logic [7:0] low_count_out
);
  logic [1:0] phase = 2'b00;
  logic last = 1'b1;
  // Pull-up wins whenever nobody sinks the line
  assign pin_level_out = !hold_low_in && (!pin_oe_in || pin_drive_in);
  assign mclk_out = phase[1];
  initial low_count_out = 8'h00;
  always @(posedge clk_in) begin
    phase <= phase + 2'b01;
    last <= pin_level_out;
    if (last && !pin_level_out) low_count_out <= low_count_out + 8'h01;
  end
endmodule

// >>> testbench/tb_act_clock_irq.sv
// Self-checking bench for the clock tree and shared pin block
`timescale 1ns/1ps
module tb_act_clock_irq;
  import act_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, mod_bit = 1'b0, crc = 1'b0, por = 1'b0;
  logic hold_low = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, hmclk, mwire, sense, mo, moe, po, poe, tick, drdy, irq;
  logic [7:0] lows, l0;
  int bad_count = 0, checks = 0, n;
  // Block wins the clock wire while it drives it
  assign mwire = moe ? mo : hmclk;
  initial forever #4 clk_in = ~clk_in;
  act_clock_irq DUT (.clk_in, .resetn_in, .mclk_pin_in(mwire), .osc_clk_in(hmclk),
    .modulator_bit_in(mod_bit), .crc_error_in(crc), .por_event_in(por),
    .irq_pin_sense_in(sense), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mclk_pin_out(mo), .mclk_pin_oe_out(moe), .irq_pin_out(po),
    .irq_pin_oe_out(poe), .sample_tick_out(tick), .data_ready_out(drdy), .irq_out(irq));
  act_host_model host (.clk_in, .pin_drive_in(po), .pin_oe_in(poe), .hold_low_in(hold_low),
    .mclk_out(hmclk), .pin_level_out(sense), .low_count_out(lows));
  task automatic bad(input string s);
    bad_count++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp) bad(s);
  endtask
  task automatic cmpb(input logic got, input logic exp, input string s);
    checks++;
    if (got !== exp) bad(s);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) bad("no pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  // Third interval only: earlier ones may straddle a settings change
  task automatic gap(input logic sel);
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while ((sel ? drdy : tick) !== 1'b1 && n < 3000);
    end
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset;
    apb(1'b0, ACT_REG_OSR, 32'h0000_0000);
    cmp(rd, 32'(ACT_OSR_RST), "osr reset");
    apb(1'b0, 8'h14, 32'h0000_0000);
    cmpb(err, 1'b1, "unmapped");
    cmpb(poe, 1'b0, "pin released");
    cmpb(sense, 1'b1, "pin high");
    $display("reset test done");
  endtask
  task automatic t_rate;
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, ACT_REG_CONFIG, 32'(p << ACT_PRE_LSB));
      gap(1'b0);
      cmp(32'(n), 32'(16 << p), "sample period");
    end
    apb(1'b1, ACT_REG_CONFIG, 32'h0000_0003);
    @(posedge clk_in);
    cmpb(moe, 1'b1, "clock pin out");
    $display("rate test done");
  endtask
  task automatic t_data;
    apb(1'b1, ACT_REG_OSR, 32'h0000_0003);
    apb(1'b1, ACT_REG_CONFIG, 32'h0000_0040);
    l0 = lows;
    gap(1'b1);
    cmp(32'(n), 32'h0000_0030, "result period");
    cmpb(8'(lows - l0) >= 8'h02, 1'b1, "pin pulses");
    apb(1'b1, ACT_REG_MASK, 32'h0000_0001);
    apb(1'b1, ACT_REG_CONFIG, 32'h0000_0010);
    @(posedge clk_in);
    cmpb(irq, 1'b1, "irq raised");
    cmpb(poe & po, 1'b1, "idle high");
    apb(1'b1, ACT_REG_STATUS, 32'h0000_0001);
    @(posedge clk_in);
    cmpb(irq, 1'b0, "irq cleared");
    $display("data test done");
  endtask
  task automatic t_bits;
    apb(1'b1, ACT_REG_CONFIG, 32'h0000_0020);
    for (int k = 0; k < 6; k++) begin
      mod_bit <= (k != 0);
      crc <= (k == 2);
      por <= (k == 3);
      if (k > 3) apb(1'b1, ACT_REG_STATUS, (k == 4) ? 32'h0000_0002 : 32'h0000_0004);
      gap(1'b0);
      cmpb(po & poe, k == 1 || k == 5, "bitstream pin");
    end
    $display("bitstream test done");
  endtask
  task automatic t_fault;
    apb(1'b1, ACT_REG_CONFIG, 32'h0000_0000);
    hold_low <= 1'b1;
    repeat (4) @(posedge clk_in);
    hold_low <= 1'b0;
    apb(1'b0, ACT_REG_STATUS, 32'h0000_0000);
    cmpb(rd[3], 1'b1, "fault seen");
    cmpb(irq, 1'b0, "fault masked");
    $display("fault test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_rate();
    t_data();
    t_bits();
    t_fault();
    end_of_test();
  end
  initial begin
    #200_000;
    bad("watchdog");
    end_of_test();
  end
endmodule
